// *** verilog/slow_ram_card.sv ***
// Operation
// - 4K byte RAM answering only its window
// - window base is switch value times 1000h
// - every access stretched by one wait state
// - wait logic fully on card, no setup
module slow_ram_card
    import slow_ram_pkg::*;
(
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire bus_req_t req_i,
    input wire logic [SEL_W-1:0] base_sel_i,
    output logic wait_req_o,
    output logic [DATA_W-1:0] rdata_o,
    output logic rdata_oe_o,
    output logic ack_o
);
    // sequencer state and its next value
    acc_state_t state;
    acc_state_t next_state;
    // latched request for the duration of an access
    bus_req_t held;
    bus_req_t next_held;
    // wait request pulse and its next value
    logic wait_req;
    logic next_wait_req;
    // data drive enable, a level while a read is answered
    logic rdata_oe;
    logic next_rdata_oe;
    // one-cycle completion pulse
    logic ack;
    logic next_ack;
    // read data holding register
    logic [DATA_W-1:0] rdata;
    logic [DATA_W-1:0] next_rdata;
    // memory port: write strobe, byte address and registered read data
    logic mem_we;
    logic [WIN_BITS-1:0] mem_addr;
    logic [DATA_W-1:0] mem_rdata;
    // a read or write strobe stands on the bus
    logic strobe;
    // request hitting our window
    logic hit;
    // request accepted by an idle sequencer
    logic take;

    // either strobe counts; both at once is a write that also returns the old byte
    assign strobe = req_i.rd | req_i.wr;

    // decode of the strobe against the switch-selected window; setting F is
    // not blocked here, keeping clear of it is left to whoever fits the card
    assign hit = strobe && in_window(req_i.addr, base_sel_i);

    // no configuration needed: any hit seen in idle starts the stretch
    assign take = (state == ST_IDLE) && hit;

    // address follows the request as it is taken, so the registered read port
    // holds the addressed byte during the wait cycle; addressing from the held
    // copy alone would hand back the byte of the previous access
    assign mem_addr = next_held.addr[WIN_BITS-1:0];

    // write happens in the wait cycle, once per access
    assign mem_we = (state == ST_WAIT) && held.wr;

    // slow storage; the extra cycle covers its registered read port
    // contents survive a reset, so nothing may expect cleared memory
    slow_ram_mem #(
        .DEPTH(RAM_DEPTH),
        .AW(WIN_BITS),
        .DW(DATA_W)
    ) u_mem (
        .clk_i(clk_i),
        .we_i(mem_we),
        .addr_i(mem_addr),
        .wdata_i(held.wdata),
        .rdata_o(mem_rdata)
    );

    // request capture: address, data and direction are kept from the take on,
    // so the far side may move its lines once the access has been answered
    always_comb
    begin
        next_held = held;
        if (take)
        begin
            // a new request replaces the old one only when it is accepted
            next_held = req_i;
        end
    end

    // held request register
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            held <= '0;
        end
        else
        begin
            held <= next_held;
        end
    end

    // one access, counted from the edge that takes it:
    //   cycle 1: wait request high, a write lands at the end of this cycle
    //   cycle 2: completion pulse, read data and drive enable up
    //   later:   drive enable holds until the strobe drops, then idle again
    // the far side must drop its strobe between accesses; a strobe that is
    // simply kept high is answered once only
    // code relying on the interrupt controller should not run from here:
    // the extra wait can upset the restart byte handed over on acknowledge
    always_comb
    begin
        next_state = state;
        case (state)
            ST_IDLE:
            begin
                // a hit starts the stretch at once
                if (take)
                begin
                    next_state = ST_WAIT;
                end
            end
            ST_WAIT:
            begin
                // exactly one wait cycle, then the answer
                next_state = ST_DONE;
            end
            ST_DONE:
            begin
                // hold off until the strobe drops, so one strobe is one access
                if (!strobe)
                begin
                    next_state = ST_IDLE;
                end
            end
            default:
            begin
                // unused code: fall back to idle rather than lock up
                next_state = ST_IDLE;
            end
        endcase
    end

    // sequencer state register
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            state <= ST_IDLE;
        end
        else
        begin
            state <= next_state;
        end
    end

    // next values of the bus-facing outputs; the wait pulse is registered, so
    // it reaches the cable one cycle after the take but never glitches
    always_comb
    begin
        next_wait_req = 1'h0;
        next_rdata_oe = 1'h0;
        next_ack = 1'h0;
        next_rdata = rdata;
        case (state)
            ST_IDLE:
            begin
                // wait goes up in the first cycle after the take
                next_wait_req = take;
            end
            ST_WAIT:
            begin
                // wait drops after one extra clock and the answer follows
                next_ack = 1'h1;
                if (held.rd)
                begin
                    // read port was addressed at the take, the byte is ready
                    next_rdata_oe = 1'h1;
                    next_rdata = mem_rdata;
                end
            end
            ST_DONE:
            begin
                // keep driving data on a read while either strobe still stands
                next_rdata_oe = held.rd && strobe;
            end
            default:
            begin
                // outputs stay quiet in an unused state
                next_rdata_oe = 1'h0;
            end
        endcase
    end

    // output registers; reset takes constants so the bus sees nothing driven
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            wait_req <= 1'h0;
            rdata_oe <= 1'h0;
            ack <= 1'h0;
            rdata <= DATA_RST;
        end
        else
        begin
            wait_req <= next_wait_req;
            rdata_oe <= next_rdata_oe;
            ack <= next_ack;
            rdata <= next_rdata;
        end
    end

    // outputs straight from flops
    assign wait_req_o = wait_req;
    assign rdata_oe_o = rdata_oe;
    assign ack_o = ack;
    assign rdata_o = rdata;
endmodule

// *** pkg/slow_ram_pkg.sv ***
package slow_ram_pkg;
    // address and data widths of the expansion bus
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    // window of 4K bytes, selected in 1000 hex steps
    localparam int WIN_BITS = 12;
    localparam int SEL_W = 4;
    localparam int RAM_DEPTH = 4096;
    // one wait state per access
    localparam int WAIT_CYCLES = 1;
    // reset values
    localparam logic [DATA_W-1:0] DATA_RST = 8'h00;

    // one processor bus request
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic rd;
        logic wr;
    } bus_req_t;

    // access sequencer states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT = 2'b01,
        ST_DONE = 2'b10
    } acc_state_t;

    // true when address lies in the window chosen by the switch
    function automatic logic in_window(input logic [ADDR_W-1:0] a,
                                       input logic [SEL_W-1:0] sel);
        in_window = (a[ADDR_W-1:WIN_BITS] == sel);
    endfunction
endpackage

// *** verilog/slow_ram_mem.sv ***
module slow_ram_mem
    import slow_ram_pkg::*;
#(
    parameter int DEPTH = RAM_DEPTH,
    parameter int AW = WIN_BITS,
    parameter int DW = DATA_W
)
(
    input wire logic clk_i,
    input wire logic we_i,
    input wire logic [AW-1:0] addr_i,
    input wire logic [DW-1:0] wdata_i,
    output logic [DW-1:0] rdata_o
);
    // static storage, no reset: contents are undefined at power up
    logic [DW-1:0] mem [DEPTH];

    // write-first is not needed: the card never uses the old byte read in a write cycle
    always_ff @(posedge clk_i)
    begin
        if (we_i)
        begin
            mem[addr_i] <= wdata_i;
        end
        rdata_o <= mem[addr_i];
    end
endmodule

// *** dv/slow_ram_card_chk.sv ***
module slow_ram_card_chk
    import slow_ram_pkg::*;
(
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire bus_req_t req_i,
    input wire logic [SEL_W-1:0] base_sel_i,
    input wire logic wait_req_o,
    input wire logic rdata_oe_o,
    input wire logic ack_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    // strobe and window decode seen at the pins
    wire strb = req_i.rd | req_i.wr, win = req_i.addr[15:12] == base_sel_i;
    sequence tk; $rose(strb) && win; endsequence
    AST_WAIT: assert property (tk |=> wait_req_o ##1 ack_o) else $error("no wait");
    AST_ONE: assert property (wait_req_o |=> !wait_req_o) else $error("long wait");
    AST_OUT: assert property ($rose(strb) && !win |=> !wait_req_o) else $error("out");
    AST_ACK: assert property (ack_o |-> $past(wait_req_o)) else $error("lone ack");
    AST_WIN: assert property (wait_req_o |-> $past(win)) else $error("window");
    AST_OE: assert property (ack_o |-> rdata_oe_o == req_i.rd) else $error("drive");
    AST_OFF: assert property (!strb && !wait_req_o |=> !rdata_oe_o) else $error("late");
    cover property (tk ##0 req_i.rd);
    cover property (tk ##0 req_i.rd && req_i.wr);
    cover property (tk ##0 req_i.wr);
    cover property ($rose(strb) && !win);
endmodule
bind slow_ram_card slow_ram_card_chk i_chk (.clk_i(clk_i), .rstn_i(rstn_i), .req_i(req_i),
    .base_sel_i(base_sel_i), .wait_req_o(wait_req_o), .rdata_oe_o(rdata_oe_o),
    .ack_o(ack_o));

// *** dv/cpu_model.sv ***
module cpu_model
    import slow_ram_pkg::*;
(
    input wire logic clk_i,
    input wire logic ack_i,
    input wire logic wait_i,
    input wire logic oe_i,
    input wire logic [DATA_W-1:0] rdata_i,
    output bus_req_t req_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // wait cycles seen and drive enable at the answer, for the last access
    int waits;
    logic drv;
    initial req_o = '0;
    // plain memory cycles only, never interrupt acknowledge
    task automatic acc(input bus_req_t r, output logic [DATA_W-1:0] q, output logic hit);
        hit = 1'h0;
        waits = 0;
        @(posedge clk_i) req_o <= r;
        // request held until ack, bounded so a refusal cannot hang
        for (int i = 0; i < 6 && !hit; i++)
        begin
            @(posedge clk_i) {hit, q, drv} = {ack_i, rdata_i, oe_i};
            waits += int'(wait_i);
        end
        // released lines show inverted values, then a gap cycle
        req_o <= '{~r.addr, ~r.wdata, 1'h0, 1'h0};
        @(posedge clk_i);
    endtask
endmodule

// *** dv/switched_base_slow_ram_decoder_tb.sv ***
module switched_base_slow_ram_decoder_tb;
    import slow_ram_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
    $display("unexpected %s exp %h got %h", nm, e, g); end end
    logic clk_i = 0, rstn_i = 0, wt, oe, ack, hit;
    logic [DATA_W-1:0] rd, q;
    logic [SEL_W-1:0] sel = 4'h0;
    bus_req_t req;
    int mismatches = 0, n_tests = 0;
    always #2.5 clk_i = ~clk_i;
    slow_ram_card i_dut (.clk_i(clk_i), .rstn_i(rstn_i), .req_i(req), .base_sel_i(sel),
        .wait_req_o(wt), .rdata_o(rd), .rdata_oe_o(oe), .ack_o(ack));
    cpu_model i_cpu (.clk_i(clk_i), .ack_i(ack), .wait_i(wt), .oe_i(oe), .rdata_i(rd),
        .req_o(req));
    task automatic close_out;
        $display("mismatches %0d checks %0d", mismatches, n_tests);
        if (mismatches == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // every usable switch value, top byte of its window
    task automatic sweep;
        for (int n = 0; n < 15; n++)
        begin
            sel <= 4'(n);
            i_cpu.acc('{{4'(n), 12'hFFF}, 8'(n), 1'h0, 1'h1}, q, hit);
            `CHK("ack", 1'h1, hit)
            `CHK("waits", WAIT_CYCLES, i_cpu.waits)
            `CHK("write drive", 1'h0, i_cpu.drv)
            i_cpu.acc('{{4'(n), 12'hFFF}, 8'h00, 1'h1, 1'h0}, q, hit);
            `CHK("data", 8'(n), q)
            `CHK("read drive", 1'h1, i_cpu.drv)
        end
    endtask
    // distinct bytes across one window, read back in another order
    task automatic spread;
        sel <= 4'h7;
        i_cpu.acc('{16'h7000, 8'hA1, 1'h0, 1'h1}, q, hit);
        i_cpu.acc('{16'h7ABC, 8'hB2, 1'h0, 1'h1}, q, hit);
        i_cpu.acc('{16'h7FFE, 8'hC3, 1'h0, 1'h1}, q, hit);
        i_cpu.acc('{16'h7ABC, 8'h00, 1'h1, 1'h0}, q, hit);
        `CHK("mid byte", 8'hB2, q)
        i_cpu.acc('{16'h7000, 8'h00, 1'h1, 1'h0}, q, hit);
        `CHK("low byte", 8'hA1, q)
        // both strobes: the byte is replaced and its old value returned
        i_cpu.acc('{16'h7FFE, 8'h5A, 1'h1, 1'h1}, q, hit);
        `CHK("old byte", 8'hC3, q)
        i_cpu.acc('{16'h7FFE, 8'h00, 1'h1, 1'h0}, q, hit);
        `CHK("new byte", 8'h5A, q)
    endtask
    // outside the window nothing answers and nothing is stored
    task automatic refuse;
        sel <= 4'h3;
        i_cpu.acc('{16'h3000, 8'h55, 1'h0, 1'h1}, q, hit);
        i_cpu.acc('{16'h4000, 8'hAA, 1'h0, 1'h1}, q, hit);
        `CHK("refused", 1'h0, hit)
        `CHK("refused wait", 32'h0, i_cpu.waits)
        `CHK("refused drive", 1'h0, i_cpu.drv)
        i_cpu.acc('{16'h3000, 8'h00, 1'h1, 1'h0}, q, hit);
        `CHK("kept", 8'h55, q)
    endtask
    initial
    begin
        repeat (6) @(posedge clk_i);
        rstn_i <= 1'h1;
        sweep();
        refuse();
        spread();
        close_out();
    end
    // watchdog far beyond the few hundred cycles needed
    initial
    begin
        #20000 mismatches++;
        close_out();
    end
endmodule
